// ===== ilc_call_unit.sv
`timescale 1ns/1ps
// Operation
// - A call first steps the stack level pointer up by one and then stores the return address, the word after the page word, in the entry it selects.
// - The page part of the counter is loaded with the page value carried by the instruction.
// - The in-page part is the three low bits of the upper offset register above the four work register bits.
// - The six page bits come from the second word, p5 and p4 above two zero bits, p3 to p0 at the bottom.
// - The return stack holds eight nested levels and deeper nesting overflows it.
module ilc_call_unit
   import ilc_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic ARST_N_I,
   input wire logic INSTR_VALID_I,
   input wire ilc_word_t INSTR_I,
   input wire logic [2:0] UPPER_OFS_I,
   input wire logic [3:0] WORK_REG_I,
   output ilc_pc_t PROGRAM_COUNTER_O,
   output logic [2:0] STACK_LEVEL_O,
   output ilc_pc_t RETURN_TOP_O,
   output logic CALL_BUSY_O,
   output logic CALL_DONE_O,
   output logic STACK_OVERFLOW_O
);

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------

   // Page field of a second word; zero bits in between are skipped
   function automatic ilc_page_t page_of(input ilc_word_t w);
      page_of = {w[`ILC_PAGE_UP_HI:`ILC_PAGE_UP_LO], w[`ILC_PAGE_LO_HI:`ILC_PAGE_LO_LO]};
   endfunction

   function automatic logic is_call(input ilc_word_t w);
      is_call = (w == `ILC_CALL_OPCODE);
   endfunction

   // ----------------------------------------------------------------
   // State update
   // ----------------------------------------------------------------
   ilc_state_s st_q;
   ilc_state_s st_d;
   logic [2:0] sp_next;
   ilc_pc_t ret_addr;

   // Return address is the word after the page word
   assign sp_next = 3'(st_q.sp + 3'h1);
   assign ret_addr = ilc_pc_t'(st_q.pc + 13'h0001);

   // Next state of counter, pointer and stack
   always_comb
   begin
      st_d = st_q;
      st_d.done = 1'b0;
      if (INSTR_VALID_I)
      begin
         unique case (st_q.state)
            ILC_IDLE:
            begin
               st_d.pc = ret_addr;
               if (is_call(INSTR_I))
               begin
                  st_d.state = ILC_WAIT_PAGE;
               end
            end
            ILC_WAIT_PAGE:
            begin
               st_d.sp = sp_next;
               st_d.stack[sp_next] = ret_addr;
               if (st_q.depth == `ILC_DEPTH_FULL)
               begin
                  st_d.overflow = 1'b1;
               end
               else
               begin
                  st_d.depth = 4'(st_q.depth + 4'h1);
               end
               st_d.pc[`ILC_PC_WIDTH-1:`ILC_WORD_WIDTH] = page_of(INSTR_I);
               // word part from D and A
               st_d.pc[`ILC_WORD_WIDTH-1:0] = {UPPER_OFS_I, WORK_REG_I};
               st_d.done = 1'b1;
               st_d.state = ILC_IDLE;
            end
         endcase
      end
      // Busy and top kept as flops so the pins never see decode glitches
      st_d.busy = (st_d.state == ILC_WAIT_PAGE);
      st_d.top = st_d.stack[st_d.sp];
   end

   // State register; stack cleared so nothing stale is read back
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         st_q <= '{state: ILC_IDLE, pc: `ILC_PC_RESET, sp: `ILC_SP_RESET, depth: 4'h0,
                   overflow: 1'b0, done: 1'b0, busy: 1'b0, top: `ILC_PC_RESET, stack: '0};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign PROGRAM_COUNTER_O = st_q.pc;
   assign STACK_LEVEL_O = st_q.sp;
   assign RETURN_TOP_O = st_q.top;
   assign CALL_BUSY_O = st_q.busy;
   assign CALL_DONE_O = st_q.done;
   assign STACK_OVERFLOW_O = st_q.overflow; // Sticky until reset

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!ARST_N_I);

   // Page word is taken on this edge
   logic take_page;
   assign take_page = INSTR_VALID_I && (st_q.state == ILC_WAIT_PAGE);

   // Pointer steps first, then the return address lands in the new entry
   a_push_order: assert property (
      take_page |=> (st_q.sp == 3'($past(st_q.sp) + 3'h1))
                    && (st_q.stack[st_q.sp] == ilc_pc_t'($past(st_q.pc) + 13'h0001)))
      else $error("push did not raise pointer then store return address");

   // Page part comes from the instruction, not from the counter
   a_page_load: assert property (
      take_page |=> st_q.pc[`ILC_PC_WIDTH-1:`ILC_WORD_WIDTH] == page_of($past(INSTR_I)))
      else $error("page part not loaded from instruction");

   // In-page part is the low offset bits above the work register
   a_word_part: assert property (
      take_page |=> st_q.pc[`ILC_WORD_WIDTH-1:0] == {$past(UPPER_OFS_I), $past(WORK_REG_I)})
      else $error("word part not formed from D and A");

   // Written without the helper, so a bad field map in it is caught
   a_page_bits: assert property (
      take_page |=> (st_q.pc[12:11] == $past(INSTR_I[7:6])) && (st_q.pc[10:7] == $past(INSTR_I[3:0])))
      else $error("page bits taken from wrong positions");

   // Overflow only on a call made with all eight levels in use
   a_depth_limit: assert property (
      $rose(STACK_OVERFLOW_O) |-> $past(st_q.depth) == `ILC_DEPTH_FULL && $past(take_page))
      else $error("overflow raised below eight levels");

   // First word arms and steps, it never redirects
   a_two_words: assert property (
      (INSTR_VALID_I && !CALL_BUSY_O && is_call(INSTR_I)) |=> CALL_BUSY_O && !CALL_DONE_O
         && PROGRAM_COUNTER_O == ilc_pc_t'($past(PROGRAM_COUNTER_O) + 13'h0001))
      else $error("first call word redirected or did not arm");

   // Done only ever follows a busy cycle
   a_done_after_busy: assert property (
      CALL_DONE_O |-> $past(CALL_BUSY_O) && !CALL_BUSY_O)
      else $error("call finished without a page word");

   // Done is a single pulse; a new call cannot finish in the next cycle
   a_done_pulse: assert property (
      CALL_DONE_O |=> !CALL_DONE_O)
      else $error("done held longer than one cycle");

   // A missing page word stalls the call without moving the counter
   a_stall_holds: assert property (
      (CALL_BUSY_O && !INSTR_VALID_I) |=> CALL_BUSY_O && $stable(PROGRAM_COUNTER_O) && $stable(STACK_LEVEL_O))
      else $error("stalled call moved counter or pointer");

   // Ordinary words only step the counter
   a_idle_step: assert property (
      (INSTR_VALID_I && !CALL_BUSY_O && !is_call(INSTR_I)) |=> !CALL_BUSY_O && $stable(STACK_LEVEL_O)
         && PROGRAM_COUNTER_O == ilc_pc_t'($past(PROGRAM_COUNTER_O) + 13'h0001))
      else $error("plain word did more than step the counter");

   // ----------------------------------------------------------------
   // Checks on the return stack
   // ----------------------------------------------------------------

   // Only the page word may touch the pointer or any stack entry
   a_stack_quiet: assert property (
      !take_page |=> $stable(st_q.stack) && $stable(STACK_LEVEL_O))
      else $error("stack changed without a call");

   // Pointer wraps from the top entry back to entry zero
   a_pointer_wrap: assert property (
      (take_page && st_q.sp == 3'h7) |=> STACK_LEVEL_O == 3'h0)
      else $error("pointer did not wrap to entry zero");

   // Top pin must track the entry the pointer selects
   a_top_register: assert property (
      RETURN_TOP_O == st_q.stack[st_q.sp])
      else $error("return top does not match selected entry");

   // Depth counts up to eight with no overflow on the way
   a_depth_count: assert property (
      (take_page && st_q.depth != `ILC_DEPTH_FULL) |=> st_q.depth == 4'($past(st_q.depth) + 4'h1)
         && !STACK_OVERFLOW_O)
      else $error("depth miscounted or overflow raised early");

   // Overflow is sticky; only reset clears it
   a_overflow_sticky: assert property (
      STACK_OVERFLOW_O |=> STACK_OVERFLOW_O)
      else $error("overflow flag dropped without reset");

   // ----------------------------------------------------------------
   // Coverage of the main call scenarios
   // ----------------------------------------------------------------
   c_single_call: cover property (take_page ##1 CALL_DONE_O);
   c_nested_two: cover property (CALL_DONE_O ##[1:20] CALL_DONE_O);
   c_overflow: cover property ($rose(STACK_OVERFLOW_O));
   c_stalled_page: cover property (CALL_BUSY_O && !INSTR_VALID_I ##1 take_page);
   c_first_push: cover property (take_page && st_q.sp == 3'h7 && st_q.depth == 4'h0);

endmodule

// ===== ilc_params.svh
`ifndef ILC_PARAMS_SVH
`define ILC_PARAMS_SVH

// ----------------------------------------------------------------
// Encodings and sizes of the indirect long call
// ----------------------------------------------------------------
`define ILC_CALL_OPCODE 10'h030
`define ILC_SECOND_TAG 2'h2
`define ILC_PC_WIDTH 13
`define ILC_PAGE_WIDTH 6
`define ILC_WORD_WIDTH 7
`define ILC_STACK_LEVELS 8
`define ILC_DEPTH_FULL 4'h8
`define ILC_SP_RESET 3'h7
`define ILC_PC_RESET 13'h0000

// ----------------------------------------------------------------
// Field positions in the second instruction word
// ----------------------------------------------------------------
`define ILC_TAG_HI 9
`define ILC_TAG_LO 8
`define ILC_PAGE_UP_HI 7
`define ILC_PAGE_UP_LO 6
`define ILC_ZERO_HI 5
`define ILC_ZERO_LO 4
`define ILC_PAGE_LO_HI 3
`define ILC_PAGE_LO_LO 0

`endif

// ===== ilc_pkg.sv
package ilc_pkg;
`include "ilc_params.svh"

   typedef logic [9:0] ilc_word_t;
   typedef logic [`ILC_PC_WIDTH-1:0] ilc_pc_t;
   typedef logic [`ILC_PAGE_WIDTH-1:0] ilc_page_t;

   typedef enum logic {ILC_IDLE, ILC_WAIT_PAGE} ilc_state_e;

   // Whole state of the call unit
   typedef struct packed {
      ilc_state_e state;
      ilc_pc_t pc;
      logic [2:0] sp;
      logic [3:0] depth;
      logic overflow;
      logic done;
      logic busy;
      ilc_pc_t top;
      ilc_pc_t [`ILC_STACK_LEVELS-1:0] stack;
   } ilc_state_s;

endpackage

// ===== ilc_prog_mem.sv
`timescale 1ns/1ps
// Program store seen by the call unit, read at the current counter
module ilc_prog_mem
   import ilc_pkg::*;
(
   input wire logic en_i,
   input wire ilc_pc_t pc_i,
   output logic valid_o,
   output ilc_word_t instr_o
);
   ilc_word_t mem [0:8191];
   // Unused words act as plain steps
   initial
   begin
      for (int i = 0; i < 8192; i++)
         mem[i] = 10'h000;
   end
   // Idle cycles show the inverted word so a stale copy is never seen
   assign valid_o = en_i;
   assign instr_o = en_i ? mem[pc_i] : ~mem[pc_i];
endmodule

// ===== tb_indirect_long_subroutine_call.sv
`timescale 1ns/1ps
module tb_indirect_long_subroutine_call;
   import ilc_pkg::*;
   logic clk;
   logic arst_n;
   logic en;
   logic [2:0] d;
   logic [3:0] a;
   logic valid;
   ilc_word_t instr;
   ilc_pc_t pc;
   ilc_pc_t top;
   logic [2:0] lvl;
   logic [2:0] elvl = 3'h7;
   logic busy;
   logic done;
   logic ovf;
   int errors = 0;
   int checks = 0;
   ilc_prog_mem u_ilc_prog_mem (.en_i(en), .pc_i(pc), .valid_o(valid), .instr_o(instr));
   ilc_call_unit u_ilc_call_unit (.SYS_CLK_I(clk), .ARST_N_I(arst_n), .INSTR_VALID_I(valid), .INSTR_I(instr),
      .UPPER_OFS_I(d), .WORK_REG_I(a), .PROGRAM_COUNTER_O(pc), .STACK_LEVEL_O(lvl), .RETURN_TOP_O(top),
      .CALL_BUSY_O(busy), .CALL_DONE_O(done), .STACK_OVERFLOW_O(ovf));
   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic check(input string name, input logic [12:0] seen, input logic [12:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // One call at the current counter; gap idles between the two words
   task automatic call(input logic [5:0] pg, input logic [2:0] dv, input logic [3:0] av, input int gap,
                       input logic ov);
      ilc_pc_t at;
      at = pc;
      u_ilc_prog_mem.mem[at] = `ILC_CALL_OPCODE;
      u_ilc_prog_mem.mem[at + 13'h0001] = {2'h2, pg[5:4], 2'h0, pg[3:0]};
      elvl = elvl + 3'h1;
      @(posedge clk);
      d <= dv;
      a <= av;
      en <= 1'b1;
      @(posedge clk);
      en <= (gap == 0);
      for (int i = 0; i < gap; i++)
      begin
         @(posedge clk);
         en <= (i == gap - 1);
      end
      @(negedge clk);
      check("busy", 13'(busy), 13'h0001);
      check("pc_wait", pc, at + 13'h0001);
      @(posedge clk);
      en <= 1'b0;
      @(negedge clk);
      check("done", 13'(done), 13'h0001);
      check("pc", pc, {pg, dv, av});
      check("level", 13'(lvl), 13'(elvl));
      check("top", top, at + 13'h0002);
      check("overflow", 13'(ovf), 13'(ov));
      @(negedge clk);
      check("done_end", 13'(done), 13'h0000);
   endtask
   // Free running clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Runaway guard, far beyond the expected seventy cycles
   initial
   begin
      #8000;
      errors++;
      summarize();
   end
   // Reset pulse: outputs checked while held, released just after a rising edge
   task automatic reset_pulse(input int hold);
      arst_n <= 1'b0;
      repeat (hold) @(posedge clk);
      @(negedge clk);
      check("rst_pc", pc, 13'h0000);
      check("rst_level", 13'(lvl), 13'h0007);
      check("rst_top", top, 13'h0000);
      check("rst_flags", {10'h000, busy, done, ovf}, 13'h0000);
      @(posedge clk);
      arst_n <= 1'b1;
      elvl = 3'h7;
   endtask
   // Plain words right after release only step the counter
   task automatic plain_steps();
      @(posedge clk);
      en <= 1'b1;
      repeat (3) @(posedge clk);
      en <= 1'b0;
      @(negedge clk);
      check("step", pc, 13'h0003);
      check("step_busy", 13'(busy), 13'h0000);
      check("step_level", 13'(lvl), 13'h0007);
   endtask
   // Nine chained calls; the ninth goes past eight levels
   task automatic nested_calls();
      for (int k = 0; k < 9; k++)
      begin
         call(6'(k * 5 + 1), 3'(k), 4'(15 - k), k % 3, k == 8);
      end
   endtask
   // Overflow outlives idle cycles, a reset in mid-run clears it, then a call into the top page
   task automatic reset_mid();
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("ovf_sticky", 13'(ovf), 13'h0001);
      @(posedge clk);
      reset_pulse(2);
      call(6'h3F, 3'h5, 4'hA, 1, 1'b0);
   endtask
   // Reset, plain steps, nested calls to overflow, reset again and one more call
   initial
   begin
      en = 1'b0;
      d = 3'h0;
      a = 4'h0;
      reset_pulse(8);
      plain_steps();
      nested_calls();
      reset_mid();
      summarize();
   end
endmodule
